// ### hw/src_map.svh
`ifndef SRC_MAP_SVH
`define SRC_MAP_SVH
// ==========================================================
// Register map
`define SRC_REG_OFFSET 8'h40
`define SRC_BIT_PRESERVE 15
`define SRC_BIT_CPU_RESET 14
`define SRC_BIT_SELFTEST 13
`define SRC_BIT_SLEEP 10
`define SRC_BIT_REFRESH_RST 9
`define SRC_BIT_STALL_INDEP 8
`define SRC_WRITE_MASK 16'he300
`define SRC_RESET_VALUE 16'h0000
// ==========================================================
// Timing
`define SRC_CLK_PERIOD_NS 40
`define SRC_RST_HOLD_NS 1000
`define SRC_RST_HOLD_CYC ((`SRC_RST_HOLD_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_TAIL_CYC 2
`endif

// ### hw/src_pkg.sv
`default_nettype none
package src_pkg;
  // Sequencer states for the processor reset pin
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_QUIET, ST_HOLD, ST_TAIL
  } src_state_e;
  // One configuration access, taken in one clock
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } src_cfg_s;
endpackage : src_pkg
`default_nettype wire

// ### hw/src_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "src_map.svh"
module src_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic hard_rst,
  input wire src_pkg::src_cfg_s cfg,
  input wire logic cfg_wr_done,
  output logic [15:0] cfg_rd_data,
  output logic cfg_rd_valid,
  input wire logic pending_txn,
  input wire logic refresh_done,
  input wire logic soft_reset_msg,
  input wire logic sleep_ack_sent,
  input wire logic channels_calibrated,
  input wire logic platform_reset_in_n,
  input wire logic block_next_request_n,
  input wire logic bus_init_signal_n,
  input wire logic boot_flag_set,
  input wire logic boot_flag_reset,
  input wire logic [31:0] config_value,
  output logic cpu_reset_n,
  output logic [32:0] addr_out,
  output logic addr_oe,
  output logic bus_stall,
  output logic config_hold,
  output logic boot_flag
);
  localparam int RST_HOLD = `SRC_RST_HOLD_CYC;
  localparam logic [7:0] HOLD_LAST = 8'(`SRC_RST_HOLD_CYC - 1);
  localparam logic [7:0] TAIL_LAST = 8'(`SRC_TAIL_CYC - 1);

  logic [15:0] ctrl;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic plat_prev;
  logic plat_released;
  logic ctrl_hit;
  logic reset_start;
  logic [7:0] cnt;
  src_pkg::src_state_e state;

  // ==========================================================
  // Pin synchronisers
  // Stage one feeds stage two only; metastability stays contained
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= (gi == 0) ? platform_reset_in_n :
                       (gi == 1) ? block_next_request_n : bus_init_signal_n;
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign ctrl_hit = cfg.wr && cfg.be[1] && (cfg.addr == `SRC_REG_OFFSET);
  // Refresh completion skips the pending wait; software and message paths go via QUIET
  assign reset_start = (state == src_pkg::ST_IDLE) && ctrl[`SRC_BIT_REFRESH_RST] && refresh_done;

  // ==========================================================
  // Control register
  // Only the high byte carries fields; low byte reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= `SRC_RESET_VALUE;
    end else begin
      if (hard_rst) begin
        ctrl[`SRC_BIT_PRESERVE] <= 1'b0;
        if (!ctrl[`SRC_BIT_PRESERVE]) begin
          ctrl[`SRC_BIT_CPU_RESET] <= 1'b0;
          ctrl[`SRC_BIT_SELFTEST] <= 1'b0;
          ctrl[`SRC_BIT_REFRESH_RST] <= 1'b0;
        end
      end else if (ctrl_hit) begin
        ctrl <= (ctrl & ~`SRC_WRITE_MASK) | (cfg.wdata & `SRC_WRITE_MASK);
      end
      // Request bit self-clears once the pin goes low
      if (state == src_pkg::ST_HOLD && cnt == 8'h00) begin
        ctrl[`SRC_BIT_CPU_RESET] <= 1'b0;
      end
      // Set beats clear when both land together
      if (sleep_ack_sent) begin
        ctrl[`SRC_BIT_SLEEP] <= 1'b1;
      end else if (channels_calibrated && plat_released) begin
        ctrl[`SRC_BIT_SLEEP] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Platform reset release tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      plat_prev <= 1'b1;
      plat_released <= 1'b0;
    end else begin
      plat_prev <= sync2[0];
      if (sync2[0] && !plat_prev) begin
        plat_released <= 1'b1;
      end else if (channels_calibrated || !sync2[0]) begin
        plat_released <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register reads, answered one clock later
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rd_data <= 16'h0000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg.rd;
      cfg_rd_data <= (cfg.rd && cfg.addr == `SRC_REG_OFFSET) ? {ctrl[15:8], 8'h00} : 16'h0000;
    end
  end

  // ==========================================================
  // Processor reset sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= src_pkg::ST_IDLE;
      cnt <= 8'h00;
      cpu_reset_n <= 1'b1;
      addr_oe <= 1'b0;
    end else begin
      case (state)
        src_pkg::ST_IDLE: begin
          if (reset_start) begin
            state <= src_pkg::ST_HOLD;
            cnt <= 8'h00;
            cpu_reset_n <= 1'b0;
            addr_oe <= 1'b1;
          end else if (soft_reset_msg) begin
            state <= src_pkg::ST_QUIET;
          end else if (ctrl_hit && cfg.wdata[`SRC_BIT_CPU_RESET]) begin
            state <= src_pkg::ST_ARMED;
          end
        end
        src_pkg::ST_ARMED: begin
          // Write must finish before the reset disturbs its path
          if (cfg_wr_done) begin
            state <= src_pkg::ST_QUIET;
          end
        end
        src_pkg::ST_QUIET: begin
          // Pending traffic drains here; the pin falls only once pending_txn clears
          if (!pending_txn) begin
            state <= src_pkg::ST_HOLD;
            cnt <= 8'h00;
            cpu_reset_n <= 1'b0;
            addr_oe <= 1'b1;
          end
        end
        src_pkg::ST_HOLD: begin
          if (cnt == HOLD_LAST) begin
            state <= src_pkg::ST_TAIL;
            cnt <= 8'h00;
            cpu_reset_n <= 1'b1;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        src_pkg::ST_TAIL: begin
          if (cnt == TAIL_LAST) begin
            state <= src_pkg::ST_IDLE;
            cnt <= 8'h00;
            addr_oe <= 1'b0;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= src_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration value drive and stall mode, boot flag
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_out <= 33'h000000000;
      bus_stall <= 1'b0;
      config_hold <= 1'b0;
      boot_flag <= 1'b0;
    end else begin
      addr_out <= {config_value, ctrl[`SRC_BIT_SELFTEST]};
      // Mode 0 lets a bus-init raise a stall as well
      if (ctrl[`SRC_BIT_STALL_INDEP]) begin
        bus_stall <= !sync2[1];
      end else begin
        bus_stall <= !sync2[1] || !sync2[2];
      end
      config_hold <= ctrl[`SRC_BIT_PRESERVE];
      if (boot_flag_reset) begin
        boot_flag <= 1'b0;
      end else if (boot_flag_set) begin
        boot_flag <= 1'b1;
      end else if (hard_rst && !ctrl[`SRC_BIT_PRESERVE]) begin
        boot_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_write_completes_first: assert property (@(posedge clk) disable iff (srst)
    (state == src_pkg::ST_ARMED && !cfg_wr_done) |=> cpu_reset_n)
    else $error("reset began before write completed");
  chk_quiet_then_assert: assert property (@(posedge clk) disable iff (srst)
    (state == src_pkg::ST_QUIET && !pending_txn) |=> !cpu_reset_n ##1 !cpu_reset_n)
    else $error("reset not asserted when idle");
  chk_pending_blocks_reset: assert property (@(posedge clk) disable iff (srst)
    (state == src_pkg::ST_QUIET && pending_txn) |=> cpu_reset_n)
    else $error("reset asserted with pending traffic");
  chk_hold_time_exact: assert property (@(posedge clk) disable iff (srst)
    $fell(cpu_reset_n) |-> ##RST_HOLD $rose(cpu_reset_n))
    else $error("reset hold time wrong");
  chk_tail_drive: assert property (@(posedge clk) disable iff (srst)
    $rose(cpu_reset_n) |-> addr_oe ##1 addr_oe ##1 !addr_oe)
    else $error("config drive tail wrong");
  chk_drive_during_reset: assert property (@(posedge clk) disable iff (srst)
    !cpu_reset_n |-> addr_oe)
    else $error("config not driven in reset");
  chk_selftest_line: assert property (@(posedge clk) disable iff (srst)
    (addr_oe && $past(ctrl[`SRC_BIT_SELFTEST])) |-> addr_out[0])
    else $error("address line three not asserted");
  chk_sleep_sets: assert property (@(posedge clk) disable iff (srst)
    sleep_ack_sent |=> ctrl[`SRC_BIT_SLEEP])
    else $error("sleep flag not set");
  chk_preserve_clears: assert property (@(posedge clk) disable iff (srst)
    hard_rst |=> !ctrl[`SRC_BIT_PRESERVE])
    else $error("preserve bit survived reset");
  chk_preserve_keeps: assert property (@(posedge clk) disable iff (srst)
    (hard_rst && ctrl[`SRC_BIT_PRESERVE]) |=> $stable(ctrl[`SRC_BIT_REFRESH_RST]))
    else $error("preserved field cleared");
  chk_refresh_reset: assert property (@(posedge clk) disable iff (srst)
    reset_start |=> !cpu_reset_n)
    else $error("refresh reset missing");
  chk_stall_indep: assert property (@(posedge clk) disable iff (srst)
    ctrl[`SRC_BIT_STALL_INDEP] |=> bus_stall == !$past(sync2[1]))
    else $error("stall depends on bus init");
endmodule : src_top
`default_nettype wire

// ### tb/src_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Processor bus side: pending work, reset width, sampled straps
module src_cpu_model (
  input wire logic clk,
  input wire logic cpu_reset_n,
  input wire logic [32:0] addr_out,
  input wire logic addr_oe,
  input wire logic [7:0] busy_len,
  input wire logic busy_go,
  output logic pending_txn,
  output logic [7:0] low_len,
  output logic [7:0] tail_len,
  output logic [32:0] config_seen
);
  logic prev_n = 1'b1;
  logic [7:0] busy_cnt = 8'h00;
  // Work in flight; a processor held in reset has none left
  always_ff @(posedge clk) begin
    if (!cpu_reset_n) busy_cnt <= 8'h00;
    else if (busy_go) busy_cnt <= busy_len;
    else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
  end
  assign pending_txn = busy_cnt != 8'h00;
  // Counts restart on each fall, so one sequence is seen at a time
  always_ff @(posedge clk) begin
    prev_n <= cpu_reset_n;
    if (prev_n && !cpu_reset_n) begin
      low_len <= 8'h01;
      tail_len <= 8'h00;
    end else if (!cpu_reset_n) low_len <= low_len + 8'h01;
    else if (addr_oe) tail_len <= tail_len + 8'h01;
    if (!cpu_reset_n && addr_oe) config_seen <= addr_out;
  end
endmodule : src_cpu_model
`default_nettype wire

// ### tb/src_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "src_map.svh"
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", w, e, g); end end
module src_top_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  src_pkg::src_cfg_s cfg = '0;
  logic [8:0] pv = '0;
  logic [2:0] lv = 3'h7;
  logic [31:0] config_value = 32'h00000000;
  logic [7:0] busy_len = 8'h00;
  logic [15:0] cfg_rd_data;
  logic [32:0] addr_out, config_seen;
  logic [7:0] low_len, tail_len;
  logic cfg_rd_valid, pending_txn, cpu_reset_n, addr_oe, bus_stall, config_hold, boot_flag;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // ==========
  // Clock, reset and hang guard
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  src_top u_src_top (.clk(clk), .srst(srst), .hard_rst(pv[7]), .cfg(cfg),
    .cfg_wr_done(pv[0]), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid),
    .pending_txn(pending_txn), .refresh_done(pv[1]), .soft_reset_msg(pv[2]),
    .sleep_ack_sent(pv[3]), .channels_calibrated(pv[4]), .platform_reset_in_n(lv[0]),
    .block_next_request_n(lv[2]), .bus_init_signal_n(lv[1]), .boot_flag_set(pv[5]),
    .boot_flag_reset(pv[6]), .config_value(config_value), .cpu_reset_n(cpu_reset_n),
    .addr_out(addr_out), .addr_oe(addr_oe), .bus_stall(bus_stall),
    .config_hold(config_hold), .boot_flag(boot_flag));
  src_cpu_model u_src_cpu_model (.clk(clk), .cpu_reset_n(cpu_reset_n),
    .addr_out(addr_out), .addr_oe(addr_oe), .busy_len(busy_len), .busy_go(pv[8]),
    .pending_txn(pending_txn), .low_len(low_len), .tail_len(tail_len),
    .config_seen(config_seen));
  // ==========
  // Shared drivers; pulses are one clock wide
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pls(int k);
    @(posedge clk) pv <= 9'h001 << k;
    @(posedge clk) pv <= '0;
  endtask : pls
  task automatic wr(logic [15:0] d, logic [1:0] be);
    @(posedge clk) cfg <= {1'b1, 1'b0, 8'h40, be, d};
    @(posedge clk) cfg <= '0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge clk) cfg <= {1'b0, 1'b1, a, 2'h0, 16'h0000};
    @(posedge clk) cfg <= '0;
    #1;
    `CHK("rd_valid", 1'b1, cfg_rd_valid)
    `CHK("rd_data", e, cfg_rd_data)
  endtask : rd
  // Waits out one whole reset sequence, then judges width, straps, tail
  task automatic seq(logic [32:0] e);
    int i;
    for (i = 0; i < 60 && cpu_reset_n === 1'b1; i++) tick(1);
    for (i = 0; i < 40 && cpu_reset_n !== 1'b1; i++) tick(1);
    tick(4);
    `CHK("low_len", 8'(`SRC_RST_HOLD_CYC), low_len)
    `CHK("config_seen", e, config_seen)
    `CHK("tail_len", 8'(`SRC_TAIL_CYC), tail_len)
  endtask : seq
  // ==========
  // Scenarios
  task automatic t_pres();
    rd(8'h44, 16'h0000);
    wr(16'h8200, 2'h3);
    pls(5);
    tick(1);
    `CHK("hold", 1'b1, config_hold)
    pls(7);
    rd(8'h40, 16'h0200);
    `CHK("boot_flag", 1'b1, boot_flag)
    pls(7);
    rd(8'h40, 16'h0000);
    `CHK("boot_flag", 1'b0, boot_flag)
    pls(5);
    pls(6);
    tick(1);
    `CHK("boot_flag", 1'b0, boot_flag)
    wr(16'h8000, 2'h1);
    rd(8'h40, 16'h0000);
    $display("test preserve done");
  endtask : t_pres
  task automatic t_sleep();
    wr(16'h0400, 2'h3);
    rd(8'h40, 16'h0000);
    pls(3);
    rd(8'h40, 16'h0400);
    pls(4);
    rd(8'h40, 16'h0400);
    @(posedge clk) lv <= 3'h6;
    tick(4);
    @(posedge clk) lv <= 3'h7;
    tick(4);
    rd(8'h40, 16'h0400);
    pls(4);
    rd(8'h40, 16'h0000);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_cpu();
    @(posedge clk) config_value <= 32'h5a3c_96e1;
    busy_len <= 8'h1e;
    pls(8);
    wr(16'h6000, 2'h3);
    tick(6);
    `CHK("rst_n early", 1'b1, cpu_reset_n)
    pls(0);
    tick(3);
    `CHK("rst_n busy", 1'b1, cpu_reset_n)
    seq({32'h5a3c_96e1, 1'b1});
    rd(8'h40, 16'h2000);
    wr(16'h0200, 2'h3);
    pls(1);
    seq({32'h5a3c_96e1, 1'b0});
    wr(16'h0000, 2'h3);
    pls(2);
    seq({32'h5a3c_96e1, 1'b0});
    rd(8'h40, 16'h0000);
    $display("test cpu_reset done");
  endtask : t_cpu
  task automatic t_stall();
    @(posedge clk) lv <= 3'h5;
    tick(4);
    `CHK("stall m0", 1'b1, bus_stall)
    wr(16'h0100, 2'h3);
    tick(4);
    `CHK("stall m1", 1'b0, bus_stall)
    @(posedge clk) lv <= 3'h3;
    tick(4);
    `CHK("stall block", 1'b1, bus_stall)
    $display("test stall done");
  endtask : t_stall
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    tick(1);
    `CHK("rst_n", 1'b1, cpu_reset_n)
    `CHK("hold", 1'b0, config_hold)
    t_pres();
    t_sleep();
    t_cpu();
    t_stall();
    stop_test();
  end
endmodule : src_top_tb_top
`default_nettype wire
